// >>> rtl/goc_params.svh
// offsets, reset values, masks and field positions of the output configuration registers
`ifndef GOC_PARAMS_SVH
`define GOC_PARAMS_SVH

`define GOC_ADDR_W          8
`define GOC_DATA_W          8

`define GOC_ADDR_LPF        8'h02
`define GOC_ADDR_DSP3       8'h03
`define GOC_ADDR_RATECTL    8'h0b
`define GOC_ADDR_CALCMD     8'h0c
`define GOC_ADDR_TEMPFMT    8'h1c
`define GOC_ADDR_SERIAL     8'h1f

`define GOC_RST_LPF         8'h06
`define GOC_RST_DSP3        8'h00
`define GOC_RST_RATECTL     8'h01
`define GOC_RST_TEMPFMT     8'h4b
`define GOC_RST_SERIAL      8'h01

`define GOC_WMASK_LPF       8'h7f
`define GOC_WMASK_DSP3      8'h67
`define GOC_WMASK_RATECTL   8'h3f
`define GOC_WMASK_TEMPFMT   8'h7f
`define GOC_WMASK_SERIAL    8'h03

`define GOC_BIT_RATE_WIDTH  2
`define GOC_BIT_CAL_EN      6
`define GOC_POS_TEMP_WIDTH  5
`define GOC_POS_PIN_SEL     2
`define GOC_BIT_SPI_WIRES   1
`define GOC_BIT_I2C_EN      0
`define GOC_POS_LPF_ORDER   4
`define GOC_POS_LPF_CUTOFF  0

`define GOC_LPF_ORDER_BAD   2'h3
`define GOC_LPF_CUTOFF_MAX  4'hd
`define GOC_TEMP_WIDTH_BAD  2'h3

`define GOC_RATE_W          24
`define GOC_RATE_NARROW_W   16

`endif

// >>> rtl/goc_pkg.sv
// types shared by the output configuration register bank
package goc_pkg;
	typedef enum logic [1:0] {
		GOC_TEMP_8  = 2'h0,
		GOC_TEMP_10 = 2'h1,
		GOC_TEMP_12 = 2'h2,
		GOC_TEMP_NA = 2'h3
	} goc_temp_width_t;

	typedef enum logic [1:0] {
		GOC_LPF_2ND = 2'h0,
		GOC_LPF_3RD = 2'h1,
		GOC_LPF_4TH = 2'h2,
		GOC_LPF_NA  = 2'h3
	} goc_lpf_order_t;
endpackage

// >>> rtl/goc_zero_cal.sv
// zero-rate offset capture and correction of the angular rate stream
`timescale 1ns/1ps
`include "goc_params.svh"

module goc_zero_cal #(
	parameter int RATE_W = `GOC_RATE_W
) (
	input  wire logic                     mclk,
	input  wire logic                     sys_rst,
	input  wire logic                     calStart,
	input  wire logic                     calApply,
	input  wire logic                     wideOut,
	input  wire logic signed [RATE_W-1:0] rateIn,
	input  wire logic                     rateInValid,
	output logic signed [RATE_W-1:0]      rateOut,
	output logic                          rateOutValid
);
	localparam int NARROW_W = `GOC_RATE_NARROW_W;

	logic signed [RATE_W-1:0] offset;
	logic signed [RATE_W-1:0] next_offset;
	logic signed [RATE_W-1:0] next_rateOut;
	logic                     next_rateOutValid;
	logic signed [RATE_W-1:0] corrected;

	// offset taken at once, corrected output follows
	always_comb begin
		next_offset = offset;
		if (calStart) begin
			next_offset = rateIn;
		end
		corrected = calApply ? RATE_W'(rateIn - offset) : rateIn;
		next_rateOut = rateOut;
		next_rateOutValid = rateInValid;
		if (rateInValid) begin
			next_rateOut = corrected;
			if (!wideOut) begin
				next_rateOut[RATE_W-NARROW_W-1:0] = '0;
			end
		end
	end

	// registers of the correction path
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			offset       <= '0;
			rateOut      <= '0;
			rateOutValid <= 1'b0;
		end else begin
			offset       <= next_offset;
			rateOut      <= next_rateOut;
			rateOutValid <= next_rateOutValid;
		end
	end
endmodule

// >>> rtl/goc_regs.sv
// output width, temperature format, serial select and filter configuration registers
// Functional notes
// - rate width bit: 16 bits clear, 24 set
// - calibration command: no data, acts at once
// - calibration command needs calibration enable set
// - clearing enable drops stored offset from output
// - temperature width 8/10/12 bits, 11 invalid
// - serial bits: 3-wire select, I2C enable
// - serial bits change only through SPI writes
// - multi-slave mode blocks serial register writes
// - lowpass order 2-4, cutoff codes 0-13
// - calibration enable bit 6, resets disabled
`timescale 1ns/1ps
`include "goc_params.svh"

module goc_regs #(
	parameter int RATE_W = `GOC_RATE_W
) (
	input  wire logic                     mclk,
	input  wire logic                     sys_rst,
	input  wire logic [`GOC_ADDR_W-1:0]   regAddr,
	input  wire logic                     regWrite,
	input  wire logic                     regRead,
	input  wire logic                     regCommand,
	input  wire logic [`GOC_DATA_W-1:0]   regWrData,
	input  wire logic                     accessViaSpi,
	input  wire logic                     multiSlaveEn,
	output logic [`GOC_DATA_W-1:0]        regRdData,
	output logic                          regRdValid,
	output logic                          rateWidthSel,
	output goc_pkg::goc_temp_width_t      tempWidthSel,
	output logic [1:0]                    serialOutPinSel,
	output logic                          spiWireCountSel,
	output logic                          i2cEnable,
	output goc_pkg::goc_lpf_order_t       lowpassOrderSel,
	output logic [3:0]                    lowpassCutoffSel,
	output logic                          zeroCalEnable,
	output logic                          calStart,
	input  wire logic signed [RATE_W-1:0] rateIn,
	input  wire logic                     rateInValid,
	output logic signed [RATE_W-1:0]      rateOut,
	output logic                          rateOutValid
);
	logic [`GOC_DATA_W-1:0] lpfReg;
	logic [`GOC_DATA_W-1:0] dsp3Reg;
	logic [`GOC_DATA_W-1:0] rateCtlReg;
	logic [`GOC_DATA_W-1:0] tempFmtReg;
	logic [`GOC_DATA_W-1:0] serialReg;
	logic [`GOC_DATA_W-1:0] next_lpfReg;
	logic [`GOC_DATA_W-1:0] next_dsp3Reg;
	logic [`GOC_DATA_W-1:0] next_rateCtlReg;
	logic [`GOC_DATA_W-1:0] next_tempFmtReg;
	logic [`GOC_DATA_W-1:0] next_serialReg;
	logic [`GOC_DATA_W-1:0] next_regRdData;
	logic                   next_regRdValid;
	logic                   next_calStart;

	// merge writable bits of a write into the old value
	function automatic logic [`GOC_DATA_W-1:0] merge(
		input logic [`GOC_DATA_W-1:0] oldVal,
		input logic [`GOC_DATA_W-1:0] newVal,
		input logic [`GOC_DATA_W-1:0] mask
	);
		merge = (oldVal & ~mask) | (newVal & mask);
	endfunction

	// register writes and read mux
	always_comb begin
		next_lpfReg     = lpfReg;
		next_dsp3Reg    = dsp3Reg;
		next_rateCtlReg = rateCtlReg;
		next_tempFmtReg = tempFmtReg;
		next_serialReg  = serialReg;
		next_regRdData  = regRdData;
		next_regRdValid = 1'b0;
		if (regWrite) begin
			if (regAddr == `GOC_ADDR_LPF) begin
				next_lpfReg = merge(lpfReg, regWrData, `GOC_WMASK_LPF);
				// unavailable codes leave the field as it was
				if (next_lpfReg[`GOC_POS_LPF_ORDER+:2] == `GOC_LPF_ORDER_BAD) begin
					next_lpfReg[`GOC_POS_LPF_ORDER+:2] = lpfReg[`GOC_POS_LPF_ORDER+:2];
				end
				if (next_lpfReg[`GOC_POS_LPF_CUTOFF+:4] > `GOC_LPF_CUTOFF_MAX) begin
					next_lpfReg[`GOC_POS_LPF_CUTOFF+:4] = lpfReg[`GOC_POS_LPF_CUTOFF+:4];
				end
			end else if (regAddr == `GOC_ADDR_DSP3) begin
				next_dsp3Reg = merge(dsp3Reg, regWrData, `GOC_WMASK_DSP3);
			end else if (regAddr == `GOC_ADDR_RATECTL) begin
				next_rateCtlReg = merge(rateCtlReg, regWrData, `GOC_WMASK_RATECTL);
			end else if (regAddr == `GOC_ADDR_TEMPFMT) begin
				next_tempFmtReg = merge(tempFmtReg, regWrData, `GOC_WMASK_TEMPFMT);
				if (next_tempFmtReg[`GOC_POS_TEMP_WIDTH+:2] == `GOC_TEMP_WIDTH_BAD) begin
					next_tempFmtReg[`GOC_POS_TEMP_WIDTH+:2] = tempFmtReg[`GOC_POS_TEMP_WIDTH+:2];
				end
			end else if (regAddr == `GOC_ADDR_SERIAL) begin
				if (accessViaSpi && !multiSlaveEn) begin
					next_serialReg = merge(serialReg, regWrData, `GOC_WMASK_SERIAL);
				end
			end
		end
		if (regRead) begin
			next_regRdValid = 1'b1;
			if (regAddr == `GOC_ADDR_LPF) begin
				next_regRdData = lpfReg;
			end else if (regAddr == `GOC_ADDR_DSP3) begin
				next_regRdData = dsp3Reg;
			end else if (regAddr == `GOC_ADDR_RATECTL) begin
				next_regRdData = rateCtlReg;
			end else if (regAddr == `GOC_ADDR_TEMPFMT) begin
				next_regRdData = tempFmtReg;
			end else if (regAddr == `GOC_ADDR_SERIAL) begin
				next_regRdData = serialReg;
			end else begin
				next_regRdData = '0; // command and unmapped locations read zero
			end
		end
	end

	// command decode, address and calibration enable, no data
	always_comb begin
		next_calStart = regCommand && (regAddr == `GOC_ADDR_CALCMD) && dsp3Reg[`GOC_BIT_CAL_EN];
	end

	// register state
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			lpfReg     <= `GOC_RST_LPF;
			dsp3Reg    <= `GOC_RST_DSP3;
			rateCtlReg <= `GOC_RST_RATECTL;
			tempFmtReg <= `GOC_RST_TEMPFMT;
			serialReg  <= `GOC_RST_SERIAL;
			regRdData  <= '0;
			regRdValid <= 1'b0;
			calStart   <= 1'b0;
		end else begin
			lpfReg     <= next_lpfReg;
			dsp3Reg    <= next_dsp3Reg;
			rateCtlReg <= next_rateCtlReg;
			tempFmtReg <= next_tempFmtReg;
			serialReg  <= next_serialReg;
			regRdData  <= next_regRdData;
			regRdValid <= next_regRdValid;
			calStart   <= next_calStart;
		end
	end

	// field outputs straight from the registers
	assign rateWidthSel     = rateCtlReg[`GOC_BIT_RATE_WIDTH];
	assign tempWidthSel     = goc_pkg::goc_temp_width_t'(tempFmtReg[`GOC_POS_TEMP_WIDTH+:2]);
	assign serialOutPinSel  = tempFmtReg[`GOC_POS_PIN_SEL+:2];
	assign spiWireCountSel  = serialReg[`GOC_BIT_SPI_WIRES];
	assign i2cEnable        = serialReg[`GOC_BIT_I2C_EN];
	assign lowpassOrderSel  = goc_pkg::goc_lpf_order_t'(lpfReg[`GOC_POS_LPF_ORDER+:2]);
	assign lowpassCutoffSel = lpfReg[`GOC_POS_LPF_CUTOFF+:4];
	assign zeroCalEnable    = dsp3Reg[`GOC_BIT_CAL_EN];

	// offset capture and correction of the rate stream
	goc_zero_cal #(
		.RATE_W (RATE_W)
	) u_zero_cal (
		.mclk         (mclk),
		.sys_rst      (sys_rst),
		.calStart     (calStart),
		.calApply     (zeroCalEnable),
		.wideOut      (rateWidthSel),
		.rateIn       (rateIn),
		.rateInValid  (rateInValid),
		.rateOut      (rateOut),
		.rateOutValid (rateOutValid)
	);
endmodule

// >>> verif/goc_host.sv
// host model presenting register accesses to the bank
`timescale 1ns/1ps
module goc_host (
	input  wire logic       mclk,
	input  wire logic [7:0] regRdData,
	input  wire logic       regRdValid,
	output logic [7:0]      regAddr,
	output logic [7:0]      regWrData,
	output logic            regWrite,
	output logic            regRead,
	output logic            regCommand,
	output logic            accessViaSpi,
	output logic            multiSlaveEn
);
	// idle bus at time zero
	initial begin
		{regAddr, regWrData, regWrite, regRead, regCommand, accessViaSpi, multiSlaveEn} = '0;
	end
	// one access, k = {command, read, write}
	task automatic acc(input logic [2:0] k, input logic [7:0] a, d, input logic spi, ms,
		output logic [7:0] q, output logic v);
		@(negedge mclk);
		regAddr = a;
		regWrData = d;
		accessViaSpi = spi;
		multiSlaveEn = ms;
		{regCommand, regRead, regWrite} = k;
		@(negedge mclk);
		{regCommand, regRead, regWrite} = 3'h0;
		regAddr = ~a; // released lines flip
		regWrData = ~d;
		q = regRdData;
		v = regRdValid;
	endtask
endmodule

// >>> verif/goc_regs_assertions.sv
// port checks of the output configuration register bank
`timescale 1ns/1ps
module goc_regs_chk #(
	parameter int RATE_W = 24
) (
	input wire logic                     mclk,
	input wire logic                     sys_rst,
	input wire logic [7:0]               regAddr,
	input wire logic                     regWrite,
	input wire logic                     regCommand,
	input wire logic [7:0]               regWrData,
	input wire logic                     accessViaSpi,
	input wire logic                     multiSlaveEn,
	input wire logic                     rateWidthSel,
	input goc_pkg::goc_temp_width_t      tempWidthSel,
	input wire logic                     spiWireCountSel,
	input wire logic                     i2cEnable,
	input wire logic [3:0]               lowpassCutoffSel,
	input wire logic                     zeroCalEnable,
	input wire logic                     calStart,
	input wire logic signed [RATE_W-1:0] rateIn,
	input wire logic                     rateInValid,
	input wire logic signed [RATE_W-1:0] rateOut
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	chk_rate_width: assert property (regWrite && regAddr == 8'h0b |=> rateWidthSel == $past(regWrData[2]))
		else $error("rate width bit wrong");
	chk_narrow_low: assert property (rateInValid && !rateWidthSel |=> rateOut[7:0] == 8'h00)
		else $error("narrow low byte not zero");
	chk_cal_start: assert property (regCommand && regAddr == 8'h0c && zeroCalEnable |=> calStart)
		else $error("calibration not started");
	chk_cal_cause: assert property (calStart |-> $past(regCommand && zeroCalEnable))
		else $error("calibration without enable");
	chk_cal_off: assert property (rateInValid && !zeroCalEnable |=> rateOut[RATE_W-1:8] == $past(rateIn[RATE_W-1:8]))
		else $error("offset applied while disabled");
	chk_temp_bad: assert property (regWrite && regAddr == 8'h1c && regWrData[6:5] == 2'h3 |=> $stable(tempWidthSel))
		else $error("invalid temperature width taken");
	chk_serial_wr: assert property (regWrite && regAddr == 8'h1f && accessViaSpi && !multiSlaveEn
		|=> {spiWireCountSel, i2cEnable} == $past(regWrData[1:0]))
		else $error("serial bits not written");
	chk_serial_lock: assert property (regWrite && regAddr == 8'h1f && (!accessViaSpi || multiSlaveEn)
		|=> $stable({spiWireCountSel, i2cEnable}))
		else $error("serial bits changed when locked");
	chk_cutoff_range: assert property (lowpassCutoffSel <= 4'hd)
		else $error("cutoff code out of range");
	chk_cal_enable: assert property (regWrite && regAddr == 8'h03 |=> zeroCalEnable == $past(regWrData[6]))
		else $error("calibration enable bit wrong");
endmodule
bind goc_regs goc_regs_chk #(.RATE_W(RATE_W)) i_goc_regs_chk (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
	.regWrite(regWrite), .regCommand(regCommand), .regWrData(regWrData), .accessViaSpi(accessViaSpi),
	.multiSlaveEn(multiSlaveEn), .rateWidthSel(rateWidthSel), .tempWidthSel(tempWidthSel),
	.spiWireCountSel(spiWireCountSel), .i2cEnable(i2cEnable), .lowpassCutoffSel(lowpassCutoffSel),
	.zeroCalEnable(zeroCalEnable), .calStart(calStart), .rateIn(rateIn), .rateInValid(rateInValid), .rateOut(rateOut));

// >>> verif/tb.sv
// self-checking bench of the output configuration register bank
`timescale 1ns/1ps
module tb;
	logic mclk = 1'b0, sys_rst = 1'b1, rateInValid = 1'b0, v, w1, s1, ie, rdv, cs, rov, ms, spi, rw, rr, rc, zce;
	logic signed [23:0] rateIn = 24'h00_0000, rateOut;
	logic [23:0] off, s;
	logic [7:0] q, ra, wd, rd;
	logic [3:0] c, cut;
	logic [1:0] o, psel;
	goc_pkg::goc_temp_width_t tws;
	goc_pkg::goc_lpf_order_t los;
	int errors = 0, total_checks = 0, seed = 32094, i, r;
	always #10 mclk = ~mclk;
	goc_host i_goc_host (.mclk(mclk), .regRdData(rd), .regRdValid(rdv), .regAddr(ra), .regWrData(wd),
		.regWrite(rw), .regRead(rr), .regCommand(rc), .accessViaSpi(spi), .multiSlaveEn(ms));
	goc_regs i_goc_regs (.mclk(mclk), .sys_rst(sys_rst), .regAddr(ra), .regWrite(rw), .regRead(rr),
		.regCommand(rc), .regWrData(wd), .accessViaSpi(spi), .multiSlaveEn(ms), .regRdData(rd), .regRdValid(rdv),
		.rateWidthSel(w1), .tempWidthSel(tws), .serialOutPinSel(psel), .spiWireCountSel(s1), .i2cEnable(ie),
		.lowpassOrderSel(los), .lowpassCutoffSel(cut), .zeroCalEnable(zce), .calStart(cs), .rateIn(rateIn),
		.rateInValid(rateInValid), .rateOut(rateOut), .rateOutValid(rov));
	// one comparison
	task automatic cmp(input string n, input logic [23:0] e, g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	// verdict and end of run
	task automatic conclude;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, d);
		i_goc_host.acc(3'h1, a, d, 1'b1, 1'b0, q, v);
	endtask
	task automatic rreg(input logic [7:0] a, e);
		i_goc_host.acc(3'h2, a, 8'h00, 1'b1, 1'b0, q, v);
		cmp("read valid", 24'(1'b1), 24'(v));
		cmp("read data", 24'(e), 24'(q));
	endtask
	// one rate sample and its corrected result
	task automatic smp(input logic [23:0] x, e);
		@(negedge mclk);
		rateIn = x;
		rateInValid = 1'b1;
		@(negedge mclk);
		rateInValid = 1'b0;
		rateIn = ~x;
		cmp("rate valid", 24'(1'b1), 24'(rov));
		cmp("rate out", e, rateOut);
	endtask
	initial begin
		repeat (20) @(negedge mclk);
		sys_rst = 1'b0;
		rreg(8'h0b, 8'h01);
		rreg(8'h1c, 8'h4b);
		rreg(8'h1f, 8'h01);
		rreg(8'h03, 8'h00);
		rreg(8'h02, 8'h06);
		rreg(8'h0c, 8'h00);
		for (i = 0; i < 8; i++) begin
			r = $random(seed);
			wreg(8'h0b, {5'h00, r[0], 2'h1});
			cmp("rate width", 24'(r[0]), 24'(w1));
		end
		for (i = 0; i < 4; i++) begin
			wreg(8'h1c, {1'b0, i[1:0], 5'h0b});
			cmp("temp width", 24'((i == 3) ? 2 : i), 24'(tws));
		end
		cmp("pin select", 24'(2'h2), 24'(psel));
		i_goc_host.acc(3'h1, 8'h1f, 8'h02, 1'b1, 1'b0, q, v);
		cmp("serial spi", 24'(2'h2), 24'({s1, ie}));
		i_goc_host.acc(3'h1, 8'h1f, 8'h01, 1'b0, 1'b0, q, v);
		cmp("serial i2c", 24'(2'h2), 24'({s1, ie}));
		i_goc_host.acc(3'h1, 8'h1f, 8'h01, 1'b1, 1'b1, q, v);
		cmp("serial multi", 24'(2'h2), 24'({s1, ie}));
		o = 2'h0;
		for (i = 0; i < 16; i++) begin
			r = $random(seed);
			wreg(8'h02, {2'h0, r[1:0], i[3:0]});
			if (i < 14) c = i[3:0];
			if (r[1:0] != 2'h3) o = r[1:0];
			cmp("cutoff", 24'(c), 24'(cut));
			cmp("order", 24'(o), 24'(los));
		end
		wreg(8'h0b, 8'h05);
		off = $random(seed);
		s = $random(seed);
		rateIn = off;
		i_goc_host.acc(3'h4, 8'h0c, 8'h00, 1'b1, 1'b0, q, v);
		cmp("cal start off", 24'(1'b0), 24'(cs));
		wreg(8'h03, 8'h40);
		cmp("cal enable set", 24'(1'b1), 24'(zce));
		rateIn = off;
		i_goc_host.acc(3'h4, 8'h0c, 8'h00, 1'b1, 1'b0, q, v);
		cmp("cal start", 24'(1'b1), 24'(cs));
		smp(s, s - off);
		wreg(8'h03, 8'h00);
		cmp("cal enable clear", 24'(1'b0), 24'(zce));
		smp(s, s);
		wreg(8'h0b, 8'h01);
		smp(s, {s[23:8], 8'h00});
		conclude();
	end
endmodule
